// file: design/lsc_regs.svh
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH
// register byte offsets
`define LSC_OFF_CMD 8'h00
`define LSC_OFF_REPLY 8'h04
`define LSC_OFF_STATUS 8'h08
`define LSC_OFF_DISP 8'h0c
`define LSC_OFF_START 8'h10
// status and display field positions
`define LSC_ST_BUSY 0
`define LSC_ST_RAVAIL 1
`define LSC_DS_LCD 0
`define LSC_DS_GFX 1
`define LSC_DS_LINES8 2
`define LSC_DS_FLASH 3
// command codes
`define LSC_CMD_MODE 8'h10
`define LSC_CMD_LCD 8'h11
`define LSC_CMD_SEL 8'h12
`define LSC_CMD_RDPTR 8'h13
`define LSC_CMD_SETPTR 8'h14
`define LSC_CMD_LINES 8'h15
`define LSC_CMD_CURMODE 8'h16
`define LSC_CMD_RDCUR 8'h17
`define LSC_CMD_SETCUR 8'h18
`define LSC_CMD_FLASH 8'h19
`define LSC_CMD_CLEAR 8'h1a
`define LSC_CMD_FONT 8'h1b
// return codes
`define LSC_RC_OK 8'h00
`define LSC_RC_BAD 8'h01
// reset values and screen geometry
`define LSC_START_RST 16'h8000
`define LSC_TOP_BITS 3'h4
`define LSC_CHR_FETCH 12'h280
`define LSC_GFX_FETCH 12'hf00
`define LSC_CHR_LINE 16'h0050
`define LSC_GFX_LINE 16'h003c
`define LSC_FONT_BYTES 4'h8
// timing
`define LSC_FLASH_UNIT_MS 100
`define LSC_CLK_KHZ 200000
`endif

// file: design/lsc_pkg.sv
package lsc_pkg;
   // one access of the memory port (vram or character generator)
   typedef struct packed {
      logic we;
      logic re;
      logic cg;
      logic [15:0] addr;
      logic [7:0] wdata;
   } lsc_mem_req_t;
   // cursor as shown on the panel
   typedef struct packed {
      logic enable;
      logic blink;
      logic block;
      logic [6:0] col;
      logic [2:0] row;
   } lsc_cursor_t;
   typedef enum logic [2:0] {
      S_IDLE, S_PARAM, S_EXEC, S_MEM, S_REPLY
   } lsc_state_t;
endpackage

// file: design/lsc_mem_seq.sv
`timescale 1ns/1ps
module lsc_mem_seq (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // burst request
   input wire logic start,
   input wire logic wr,
   input wire logic cg,
   input wire logic [15:0] base,
   input wire logic [15:0] count,
   input wire logic [7:0] wdata,
   // burst status
   output lsc_pkg::lsc_mem_req_t req,
   output logic done,
   output logic rd_valid,
   output logic [7:0] rd_data,
   // memory read data, one cycle after re
   input wire logic [7:0] mem_rdata
);
   import lsc_pkg::*;

   logic active, next_active, is_wr, next_is_wr, is_cg, next_is_cg;
   logic pend, next_pend, next_done, next_rd_valid;
   logic [15:0] addr, next_addr, left, next_left;
   logic [7:0] data, next_data, next_rd_data;
   lsc_mem_req_t next_req;

   ////////////////////////////////////////////////////////////////////////
   // one access per cycle; a zero count finishes at once to avoid a hang
   always_comb begin
      next_active = active;
      next_is_wr = is_wr;
      next_is_cg = is_cg;
      next_addr = addr;
      next_left = left;
      next_data = data;
      next_req = '0;
      next_done = 1'b0;
      next_pend = req.re;
      next_rd_valid = pend;
      next_rd_data = pend ? mem_rdata : rd_data;
      if (!active && start) begin
         next_active = (count != 16'h0000);
         next_done = (count == 16'h0000);
         next_is_wr = wr;
         next_is_cg = cg;
         next_addr = base;
         next_left = count;
         next_data = wdata;
      end else if (active) begin
         next_req.we = is_wr;
         next_req.re = ~is_wr;
         next_req.cg = is_cg;
         next_req.addr = addr;
         next_req.wdata = is_wr ? data : 8'h00;
         next_addr = addr + 16'h0001;
         next_left = left - 16'h0001;
         if (left == 16'h0001) begin
            next_active = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 1'b0;
         is_wr <= 1'b0;
         is_cg <= 1'b0;
         addr <= 16'h0000;
         left <= 16'h0000;
         data <= 8'h00;
         req <= '0;
         done <= 1'b0;
         pend <= 1'b0;
         rd_valid <= 1'b0;
         rd_data <= 8'h00;
      end else begin
         active <= next_active;
         is_wr <= next_is_wr;
         is_cg <= next_is_cg;
         addr <= next_addr;
         left <= next_left;
         data <= next_data;
         req <= next_req;
         done <= next_done;
         pend <= next_pend;
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
      end
   end
endmodule // lsc_mem_seq

// file: design/lsc_engine.sv
// Operation
// - command byte, parameters, return code, then replies
// - two-byte values travel high byte first
// - command 10 loads the whole screen layout
// - command 11 switches display, vram untouched
// - command 12 selects screen and moves start
// - command 13 replies start, top bits 100
// - command 14 loads start within vram window; code loads all 16 bits as sent, unchecked
// - fetch 640 bytes character, 3840 graphics
// - command 15 line count, held in graphics
// - command 16 sets cursor shape, blink, enable
// - graphics mode forces blinking underline cursor
// - command 17 replies cursor column and row
// - command 19 stops or sets flash period
// - no flash block defined means no flashing
// - flashed block list follows active screen
// - command 1a selects screen then fills lines
// - clear skipped when screen not configured
// - command 1b replies eight font bytes
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "lsc_regs.svh"
module lsc_engine #(
   parameter int unsigned FLASH_UNIT_CYC = `LSC_FLASH_UNIT_MS * `LSC_CLK_KHZ
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // display controls
   output logic display_on,
   output logic gfx_mode,
   output logic lines8,
   output logic [15:0] start_addr,
   output logic [11:0] fetch_len,
   output lsc_pkg::lsc_cursor_t cursor,
   output logic flash_on,
   output logic flash_phase,
   output logic [15:0] flash_base,
   // memory port
   output lsc_pkg::lsc_mem_req_t mem_req,
   input wire logic [7:0] mem_rdata
);
   import lsc_pkg::*;

   // parameter count of each command, 0 also for unknown codes
   function automatic logic [4:0] param_len(input logic [7:0] c);
      case (c)
         `LSC_CMD_MODE: param_len = 5'h10;
         `LSC_CMD_LCD, `LSC_CMD_SEL, `LSC_CMD_LINES: param_len = 5'h01;
         `LSC_CMD_CURMODE, `LSC_CMD_FLASH, `LSC_CMD_FONT: param_len = 5'h01;
         `LSC_CMD_SETPTR, `LSC_CMD_SETCUR: param_len = 5'h02;
         `LSC_CMD_CLEAR: param_len = 5'h04;
         default: param_len = 5'h00;
      endcase
   endfunction

   function automatic logic known(input logic [7:0] c);
      known = (c >= `LSC_CMD_MODE) && (c <= `LSC_CMD_FONT);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `LSC_OFF_CMD) || (a == `LSC_OFF_REPLY) ||
               (a == `LSC_OFF_STATUS) || (a == `LSC_OFF_DISP) ||
               (a == `LSC_OFF_START);
   endfunction

   lsc_state_t st, next_st;
   logic [7:0] cmd, next_cmd;
   logic [7:0] pbuf [16];
   logic [7:0] next_pbuf [16];
   logic [7:0] rbuf [9];
   logic [7:0] next_rbuf [9];
   logic [4:0] pcnt, next_pcnt;
   logic [3:0] rlen, next_rlen, ridx, next_ridx, fcnt, next_fcnt;
   logic [15:0] char_start, next_char_start, gfx_start, next_gfx_start;
   logic [15:0] cfl_start, next_cfl_start, gfl_start, next_gfl_start;
   logic [15:0] udc_start, next_udc_start, win_ptr, next_win_ptr;
   logic [15:0] next_start, next_flash_base;
   logic [7:0] udc_code, next_udc_code, flash_per, next_flash_per;
   logic [2:0] cur_mode, next_cur_mode;
   logic lines_pend, next_lines_pend, next_lines8, next_gfx, next_lcd;
   logic [11:0] next_fetch;
   lsc_cursor_t next_cursor;
   logic seq_go, seq_wr, seq_cg, seq_done, rd_valid;
   logic [15:0] seq_base, seq_count, lb;
   logic [7:0] rd_data;
   logic acc, wr_byte, pop, next_pready, next_pslverr, flash_def;
   logic [31:0] next_prdata;

   ////////////////////////////////////////////////////////////////////////
   // apb: one wait state so read data leaves a flip-flop
   assign acc = psel & penable & pready;
   assign wr_byte = acc & pwrite & (paddr == `LSC_OFF_CMD) &
                    ((st == S_IDLE) | (st == S_PARAM));
   assign pop = acc & ~pwrite & (paddr == `LSC_OFF_REPLY) &
                (st == S_REPLY);

   always_comb begin
      next_pready = psel & penable & ~pready;
      next_pslverr = 1'b0;
      next_prdata = 32'h00000000;
      if (psel & penable & ~pready) begin
         next_pslverr = ~mapped(paddr);
         case (paddr)
            `LSC_OFF_REPLY:
               next_prdata[7:0] = (st == S_REPLY) ? rbuf[ridx] : 8'h00;
            `LSC_OFF_STATUS: begin
               next_prdata[`LSC_ST_BUSY] = (st != S_IDLE);
               next_prdata[`LSC_ST_RAVAIL] = (st == S_REPLY);
            end
            `LSC_OFF_DISP: begin
               next_prdata[`LSC_DS_LCD] = display_on;
               next_prdata[`LSC_DS_GFX] = gfx_mode;
               next_prdata[`LSC_DS_LINES8] = lines8;
               next_prdata[`LSC_DS_FLASH] = flash_on;
            end
            `LSC_OFF_START: next_prdata[15:0] = start_addr;
            default: next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command engine: collect, execute, burst memory, hand back replies
   always_comb begin
      next_st = st;
      next_cmd = cmd;
      next_pbuf = pbuf;
      next_rbuf = rbuf;
      next_pcnt = pcnt;
      next_rlen = rlen;
      next_ridx = ridx;
      next_fcnt = fcnt;
      next_char_start = char_start;
      next_gfx_start = gfx_start;
      next_cfl_start = cfl_start;
      next_gfl_start = gfl_start;
      next_udc_start = udc_start;
      next_udc_code = udc_code;
      next_win_ptr = win_ptr;
      next_start = start_addr;
      next_flash_per = flash_per;
      next_cur_mode = cur_mode;
      next_lines_pend = lines_pend;
      next_lines8 = lines8;
      next_gfx = gfx_mode;
      next_lcd = display_on;
      next_cursor = cursor;
      seq_go = 1'b0;
      seq_wr = 1'b0;
      seq_cg = 1'b0;
      seq_base = 16'h0000;
      seq_count = 16'h0000;
      lb = `LSC_CHR_LINE;
      case (st)
         S_IDLE: if (wr_byte) begin
            next_cmd = pwdata[7:0];
            next_pcnt = 5'h00;
            next_st = (param_len(pwdata[7:0]) == 5'h00) ? S_EXEC : S_PARAM;
         end
         S_PARAM: if (wr_byte) begin
            next_pbuf[pcnt[3:0]] = pwdata[7:0];
            next_pcnt = pcnt + 5'h01;
            if (pcnt + 5'h01 == param_len(cmd))
               next_st = S_EXEC;
         end
         S_EXEC: begin
            next_rbuf[0] = known(cmd) ? `LSC_RC_OK : `LSC_RC_BAD;
            next_rlen = 4'h1; // an error code carries no replies
            next_ridx = 4'h0;
            next_st = S_REPLY;
            case (cmd)
               `LSC_CMD_MODE: begin // high byte first
                  next_char_start = {pbuf[0], pbuf[1]};
                  next_gfx_start = {pbuf[2], pbuf[3]};
                  next_cfl_start = {pbuf[4], pbuf[5]};
                  next_gfl_start = {pbuf[6], pbuf[7]};
                  next_udc_start = {pbuf[8], pbuf[9]};
                  next_lines_pend = (pbuf[10] != 8'h07);
                  next_udc_code = pbuf[11];
                  next_win_ptr = {pbuf[0], pbuf[1]};
                  next_lcd = (pbuf[14] != 8'h00);
                  next_gfx = (pbuf[15] == 8'h00);
                  next_start = next_gfx ? {pbuf[2], pbuf[3]} :
                                          {pbuf[0], pbuf[1]};
                  if (!next_gfx)
                     next_lines8 = next_lines_pend;
               end
               `LSC_CMD_LCD: next_lcd = (pbuf[0] != 8'h00);
               `LSC_CMD_SEL, `LSC_CMD_CLEAR: begin
                  next_gfx = (pbuf[0] == 8'h00);
                  next_start = next_gfx ? gfx_start : win_ptr;
                  if (!next_gfx)
                     next_lines8 = lines_pend;
                  if (cmd == `LSC_CMD_CLEAR) begin
                     lb = next_gfx ? `LSC_GFX_LINE : `LSC_CHR_LINE;
                     seq_base = (next_gfx ? gfx_start : char_start) +
                                16'(pbuf[2]) * lb;
                     seq_count = 16'(pbuf[3]) * lb;
                     seq_wr = 1'b1;
                     // unconfigured screen: selection only
                     seq_go = (next_gfx ? gfx_start : char_start) != 16'h0;
                     if (seq_go)
                        next_st = S_MEM;
                  end
               end
               `LSC_CMD_RDPTR: begin
                  next_rbuf[1] = {`LSC_TOP_BITS, start_addr[12:8]};
                  next_rbuf[2] = start_addr[7:0];
                  next_rlen = 4'h3;
               end
               `LSC_CMD_SETPTR: next_start = {pbuf[0], pbuf[1]};
               `LSC_CMD_LINES: begin // held until character mode
                  next_lines_pend = (pbuf[0] == 8'h00);
                  if (!gfx_mode)
                     next_lines8 = (pbuf[0] == 8'h00);
               end
               `LSC_CMD_CURMODE: next_cur_mode = pbuf[0][2:0];
               `LSC_CMD_RDCUR: begin
                  next_rbuf[1] = {1'b0, cursor.col};
                  next_rbuf[2] = {5'h00, cursor.row};
                  next_rlen = 4'h3;
               end
               `LSC_CMD_SETCUR: begin // host keeps in range
                  next_cursor.col = pbuf[0][6:0];
                  next_cursor.row = pbuf[1][2:0];
               end
               `LSC_CMD_FLASH: next_flash_per = pbuf[0];
               `LSC_CMD_FONT: begin // user area above its first code
                  seq_go = 1'b1;
                  seq_count = 16'(`LSC_FONT_BYTES);
                  seq_cg = (udc_code == 8'h00) || (pbuf[0] < udc_code);
                  seq_base = seq_cg ? 16'({pbuf[0], 3'h0}) :
                             udc_start + 16'({pbuf[0] - udc_code, 3'h0});
                  next_fcnt = 4'h0;
                  next_rlen = 4'h9;
                  next_st = S_MEM;
               end
               default: next_rlen = 4'h1;
            endcase
         end
         S_MEM: begin
            if (rd_valid) begin
               next_rbuf[fcnt + 4'h1] = rd_data;
               next_fcnt = fcnt + 4'h1;
            end
            if ((cmd == `LSC_CMD_CLEAR) ? seq_done :
                (fcnt == `LSC_FONT_BYTES))
               next_st = S_REPLY;
         end
         S_REPLY: if (pop) begin // next command only after last byte
            next_ridx = ridx + 4'h1;
            if (ridx + 4'h1 == rlen)
               next_st = S_IDLE;
         end
         default: next_st = S_IDLE;
      endcase
      // graphics overrides the configured cursor look
      next_cursor.enable = next_gfx | next_cur_mode[0];
      next_cursor.blink = next_gfx | next_cur_mode[1];
      next_cursor.block = ~next_gfx & next_cur_mode[2];
      next_fetch = next_gfx ? `LSC_GFX_FETCH : `LSC_CHR_FETCH;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= S_IDLE;
         cmd <= 8'h00;
         for (int i = 0; i < 16; i++)
            pbuf[i] <= 8'h00;
         for (int i = 0; i < 9; i++)
            rbuf[i] <= 8'h00;
         pcnt <= 5'h00;
         rlen <= 4'h0;
         ridx <= 4'h0;
         fcnt <= 4'h0;
         char_start <= 16'h0000;
         gfx_start <= 16'h0000;
         cfl_start <= 16'h0000;
         gfl_start <= 16'h0000;
         udc_start <= 16'h0000;
         udc_code <= 8'h00;
         win_ptr <= `LSC_START_RST;
         start_addr <= `LSC_START_RST;
         flash_per <= 8'h00;
         cur_mode <= 3'h0;
         lines_pend <= 1'b1;
         lines8 <= 1'b1;
         gfx_mode <= 1'b0;
         display_on <= 1'b0;
         cursor <= '0;
         fetch_len <= `LSC_CHR_FETCH;
      end else begin
         st <= next_st;
         cmd <= next_cmd;
         pbuf <= next_pbuf;
         rbuf <= next_rbuf;
         pcnt <= next_pcnt;
         rlen <= next_rlen;
         ridx <= next_ridx;
         fcnt <= next_fcnt;
         char_start <= next_char_start;
         gfx_start <= next_gfx_start;
         cfl_start <= next_cfl_start;
         gfl_start <= next_gfl_start;
         udc_start <= next_udc_start;
         udc_code <= next_udc_code;
         win_ptr <= next_win_ptr;
         start_addr <= next_start;
         flash_per <= next_flash_per;
         cur_mode <= next_cur_mode;
         lines_pend <= next_lines_pend;
         lines8 <= next_lines8;
         gfx_mode <= next_gfx;
         display_on <= next_lcd;
         cursor <= next_cursor;
         fetch_len <= next_fetch;
      end
   end

   // clears and font reads share one memory sequencer
   lsc_mem_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .start(seq_go),
      .wr(seq_wr),
      .cg(seq_cg),
      .base(seq_base),
      .count(seq_count),
      .wdata(pbuf[1]),
      .req(mem_req),
      .done(seq_done),
      .rd_valid(rd_valid),
      .rd_data(rd_data),
      .mem_rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // flash timer: unit ticks, period count, phase toggle
   logic [31:0] unit_cnt, next_unit_cnt;
   logic [7:0] per_cnt, next_per_cnt;
   logic next_flash_on, next_phase;

   assign flash_def = gfx_mode ? (gfl_start != 16'h0) : (cfl_start != 16'h0);
   always_comb begin
      next_flash_on = (flash_per != 8'h00) & flash_def;
      next_flash_base = gfx_mode ? gfl_start : cfl_start;
      next_unit_cnt = 32'h0;
      next_per_cnt = 8'h00;
      next_phase = 1'b0;
      if (flash_on) begin
         next_unit_cnt = unit_cnt + 32'h1;
         next_per_cnt = per_cnt;
         next_phase = flash_phase;
         if (unit_cnt + 32'h1 >= FLASH_UNIT_CYC) begin
            next_unit_cnt = 32'h0;
            next_per_cnt = per_cnt + 8'h01;
            if (per_cnt + 8'h01 >= flash_per) begin
               next_per_cnt = 8'h00;
               next_phase = ~flash_phase;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit_cnt <= 32'h0;
         per_cnt <= 8'h00;
         flash_on <= 1'b0;
         flash_phase <= 1'b0;
         flash_base <= 16'h0000;
      end else begin
         unit_cnt <= next_unit_cnt;
         per_cnt <= next_per_cnt;
         flash_on <= next_flash_on;
         flash_phase <= next_phase;
         flash_base <= next_flash_base;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_exec(logic [7:0] c);
      st == S_EXEC && cmd == c;
   endsequence

   a_bad_cmd_code: assert property (
      (st == S_EXEC && !known(cmd)) |=> rlen == 4'h1 && rbuf[0] != 8'h00)
      else $error("unknown command got replies or zero code");
   a_ptr_high_first: assert property (
      s_exec(`LSC_CMD_RDPTR) |=> rbuf[1] == {3'h4, start_addr[12:8]} &&
      rbuf[2] == start_addr[7:0] && rlen == 4'h3)
      else $error("pointer reply malformed");
   a_lcd_no_vram: assert property (
      s_exec(`LSC_CMD_LCD) |=> !mem_req.we [*3])
      else $error("display switch touched vram");
   a_lines_held: assert property (
      (s_exec(`LSC_CMD_LINES) and gfx_mode) |=> $stable(lines8))
      else $error("line count applied in graphics mode");
   a_gfx_cursor: assert property (
      gfx_mode |-> cursor.enable && cursor.blink && !cursor.block)
      else $error("graphics cursor not blinking underline");
   a_fetch_size: assert property (
      $rose(gfx_mode) |-> fetch_len == 12'hf00)
      else $error("graphics fetch length wrong");
   a_flash_undef: assert property (
      !flash_def |=> !flash_on)
      else $error("flashing without a block list");
   a_clear_skip: assert property (
      (s_exec(`LSC_CMD_CLEAR) and (pbuf[0] == 8'h00 ? gfx_start == 16'h0 :
      char_start == 16'h0)) |=> st == S_REPLY && !mem_req.we [*2])
      else $error("clear ran on unconfigured screen");
   a_font_reply: assert property (
      s_exec(`LSC_CMD_FONT) |-> ##[4:20] (st == S_REPLY && rlen == 4'h9))
      else $error("font reply not nine bytes in time");
   a_sel_start: assert property (
      (s_exec(`LSC_CMD_SEL) and pbuf[0] == 8'h00) |=>
      start_addr == $past(gfx_start))
      else $error("graphics select did not move start to top");
endmodule // lsc_engine

// file: verif/lsc_mem_model.sv
`timescale 1ns/1ps
module lsc_mem_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // memory port of the engine
   input lsc_pkg::lsc_mem_req_t req,
   output logic [7:0] rdata
);
   import lsc_pkg::*;
   // answers one cycle after re; otherwise toggles so stale data never matches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rdata <= 8'h00;
      else if (req.re) rdata <= req.addr[7:0] ^ 8'h5a;
      else rdata <= ~rdata;
   end
endmodule // lsc_mem_model

// file: verif/lsc_engine_tb.sv
`timescale 1ns/1ps
`include "lsc_regs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module lsc_engine_tb;
   import lsc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, mem_rdata;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, sl, display_on, gfx_mode, lines8, flash_on;
   logic flash_phase;
   logic [15:0] start_addr, flash_base;
   logic [11:0] fetch_len;
   lsc_cursor_t cursor;
   lsc_mem_req_t mem_req;
   logic [71:0] fx;
   int error_cnt = 0, total_checks = 0, we_cnt = 0;
   ////////////////////////////////////////////////////////////////////////
   lsc_engine #(.FLASH_UNIT_CYC(8)) dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .display_on(display_on), .gfx_mode(gfx_mode), .lines8(lines8),
      .start_addr(start_addr), .fetch_len(fetch_len), .cursor(cursor),
      .flash_on(flash_on), .flash_phase(flash_phase), .flash_base(flash_base),
      .mem_req(mem_req), .mem_rdata(mem_rdata));
   lsc_mem_model mem (.pclk(pclk), .presetn(presetn), .req(mem_req),
      .rdata(mem_rdata));
   // clock and a count of vram writes to spot unwanted clears
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) if (mem_req.we === 1'b1) we_cnt++;
   ////////////////////////////////////////////////////////////////////////
   // one apb transfer; holds the request until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata; sl = pslverr; psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   // send n command bytes, poll for the answer, compare m reply bytes
   task xfer(input int n, input logic [135:0] c, input int m,
             input logic [71:0] e);
      int k;
      for (int i = 0; i < n; i++) apb(1, `LSC_OFF_CMD, c[8*(n-1-i)+:8]);
      k = 0;
      do begin apb(0, `LSC_OFF_STATUS, 0); k++; end
      while (r[`LSC_ST_RAVAIL] !== 1'b1 && k < 300);
      `CHK(r[`LSC_ST_RAVAIL], 1'b1)
      for (int i = 0; i < m; i++) begin
         apb(0, `LSC_OFF_REPLY, 0);
         `CHK(r[7:0], e[8*(m-1-i)+:8])
      end
      apb(0, `LSC_OFF_STATUS, 0);
      `CHK(r, 32'h0)
   endtask
   // closing verdict, reached from the main flow or the watchdog
   task end_of_test;
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // scenarios; the host waits for each exchange to finish
   task t_reset;
      repeat (3) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      `CHK({lines8, fetch_len}, {1'b1, 12'h280})
      `CHK(start_addr, 16'h8000)
   endtask
   task t_pointer;
      xfer(1, 8'h13, 3, 24'h008000);
      xfer(3, 24'h149123, 1, 8'h00);
      `CHK(start_addr, 16'h9123)
      xfer(1, 8'h13, 3, 24'h009123);
   endtask
   task t_display;
      xfer(2, 16'h1100, 1, 8'h00);
      `CHK(display_on, 1'b0)
      xfer(2, 16'h1105, 1, 8'h00);
      `CHK(display_on, 1'b1)
      xfer(2, 16'h1200, 1, 8'h00);
      `CHK({gfx_mode, fetch_len}, {1'b1, 12'hf00})
      `CHK(cursor[12:10], 3'b110)
      xfer(2, 16'h1501, 1, 8'h00);
      `CHK(lines8, 1'b1)
      xfer(2, 16'h1903, 1, 8'h00);
      `CHK(flash_on, 1'b0)
      xfer(5, 40'h1a01ff0001, 1, 8'h00);
      `CHK({gfx_mode, lines8}, 2'b00)
      `CHK(we_cnt, 0)
   endtask
   task t_cursor;
      xfer(2, 16'h1607, 1, 8'h00);
      xfer(3, 24'h180503, 1, 8'h00);
      xfer(1, 8'h17, 3, 24'h000503);
      `CHK(cursor, {3'b111, 7'd5, 3'd3})
      xfer(1, 8'h20, 1, 8'h01);
      apb(0, 8'h40, 0);
      `CHK({sl, r}, {1'b1, 32'h0})
   endtask
   // return code byte leads, then eight font bytes from the model
   task t_font(input logic [7:0] code, input logic [7:0] lo);
      fx = 72'h0;
      for (int i = 0; i < 8; i++) fx[8*(7-i)+:8] = (lo + 8'(i)) ^ 8'h5a;
      xfer(2, {8'h1b, code}, 9, fx);
   endtask
   // full layout: flash lists, a real clear, user font area
   task t_layout;
      logic [135:0] lay;
      logic p;
      lay = {8'h10, 64'h8000_8800_9000_9100, 16'h9200, 16'h08e0,
             32'h0000_0101};
      xfer(17, lay, 1, 8'h00);
      `CHK({start_addr, gfx_mode, lines8}, {16'h8000, 2'b01})
      `CHK({display_on, flash_on, flash_base}, {2'b11, 16'h9000})
      xfer(5, 40'h1a01200102, 1, 8'h00);
      `CHK(we_cnt, 160)
      xfer(2, 16'h1200, 1, 8'h00);
      `CHK({start_addr, flash_base}, {16'h8800, 16'h9100})
      p = flash_phase;
      repeat (24) @(posedge pclk);
      `CHK(flash_phase, ~p)
      t_font(8'he2, 8'h10);
   endtask
   initial begin
      t_reset;
      t_pointer;
      t_display;
      t_cursor;
      t_font(8'h41, 8'h08);
      t_layout;
      end_of_test;
   end
   // watchdog well beyond the expected run
   initial begin
      #200000;
      error_cnt++;
      end_of_test;
   end
endmodule // lsc_engine_tb
